//--- src/ccr_pkg.sv
// Purpose: shared constants, field layouts and types of the charger control registers
// Assumes: 10 MHz system clock, 8-bit registers
// Notes: setpoints are carried in engineering units (mV, mOhm, percent, 0.1 A)
package ccr_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int MS_PER_S = 1000;
	localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;

	// register offsets
	localparam logic [7:0] ADDR_CTRL_A = 8'h0b;
	localparam logic [7:0] ADDR_CTRL_B = 8'h0c;
	localparam logic [7:0] ADDR_CTRL_C = 8'h0d;

	// reset values, also the image used before nonvolatile contents arrive
	localparam logic [7:0] RST_CTRL_A = 8'h98;
	localparam logic [7:0] RST_CTRL_B = 8'h40;
	localparam logic [7:0] RST_CTRL_C = 8'h49;

	// timing, in milliseconds
	localparam logic [10:0] OV_FILTER_MS = 11'h028;
	localparam logic [10:0] START_DLY0_MS = 11'h000;
	localparam logic [10:0] START_DLY1_MS = 11'h0dc;
	localparam logic [10:0] START_DLY2_MS = 11'h1f4;
	localparam logic [10:0] START_DLY3_MS = 11'h514;

	// switch current limits in 0.1 A
	localparam logic [6:0] LIMIT_REDUCED_DA = 7'h39;
	localparam logic [6:0] LIMIT_LOW_DA = 7'h55;
	localparam logic [6:0] LIMIT_HIGH_DA = 7'h64;

	// step sizes and base of linear fields
	localparam logic [8:0] CLAMP_STEP_MV = 9'h03c;
	localparam logic [7:0] COMP_STEP_MOHM = 8'h14;
	localparam logic [9:0] BATGOOD_BASE_MV = 10'h190;
	localparam logic [9:0] BATGOOD_STEP_MV = 10'h0c8;

	// field layout, msb first
	typedef struct packed {
		logic overvoltage_filter_enable;
		logic [2:0] short_threshold;
		logic [1:0] short_current;
		logic aux_supply_manual;
		logic aux_supply_source;
	} ccr_ctrl_a_t;

	typedef struct packed {
		logic reduced_switch_limit;
		logic done_enable;
		logic [2:0] path_comp_clamp;
		logic [2:0] path_resistance_comp;
	} ccr_ctrl_b_t;

	typedef struct packed {
		logic [2:0] restart_margin;
		logic [1:0] charger_start_delay;
		logic ignore_aux_supply_fault;
		logic [1:0] battery_ok_threshold;
	} ccr_ctrl_c_t;

	typedef struct packed {
		ccr_ctrl_a_t a;
		ccr_ctrl_b_t b;
		ccr_ctrl_c_t c;
	} ccr_image_t;

	typedef struct packed {
		logic [13:0] short_threshold_mv;
		logic [3:0] short_current_pct;
		logic aux_from_battery;
		logic [6:0] switch_limit_da;
		logic [8:0] clamp_mv;
		logic [7:0] comp_mohm;
		logic [9:0] restart_mv;
		logic [9:0] battery_ok_mv;
	} ccr_setpoints_t;

	typedef enum logic [2:0] {
		CCR_IDLE = 3'h0,
		CCR_DELAY = 3'h1,
		CCR_CHARGE = 3'h3,
		CCR_DONE = 3'h2,
		CCR_FAULT = 3'h6
	} ccr_state_t;

	function automatic logic [13:0] short_mv(input logic [2:0] code);
		case (code)
			3'h0: short_mv = 14'h0fa0;
			3'h1: short_mv = 14'h1388;
			3'h2: short_mv = 14'h1770;
			3'h3: short_mv = 14'h1d4c;
			3'h4: short_mv = 14'h1f40;
			3'h5: short_mv = 14'h2710;
			3'h6: short_mv = 14'h2710;
			default: short_mv = 14'h30d4;
		endcase
	endfunction

	function automatic logic [9:0] restart_mv(input logic [2:0] code);
		case (code)
			3'h0: restart_mv = 10'h0c8;
			3'h1: restart_mv = 10'h12c;
			3'h2: restart_mv = 10'h190;
			3'h3: restart_mv = 10'h1c2;
			3'h4: restart_mv = 10'h1f4;
			3'h5: restart_mv = 10'h258;
			3'h6: restart_mv = 10'h2ee;
			default: restart_mv = 10'h320;
		endcase
	endfunction

	function automatic logic [10:0] start_ms(input logic [1:0] code);
		case (code)
			2'h0: start_ms = START_DLY0_MS;
			2'h1: start_ms = START_DLY1_MS;
			2'h2: start_ms = START_DLY2_MS;
			default: start_ms = START_DLY3_MS;
		endcase
	endfunction

endpackage

//--- src/ccr_ms_timer.sv
// Purpose: millisecond interval timer driven by a one-cycle tick enable
// Assumes: tick_i is a single-cycle pulse once per millisecond
// Notes: done after more than target ticks, or at once for a zero target, so the wait is never short
`timescale 1ns/1ns
module ccr_ms_timer import ccr_pkg::*; (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic [10:0] target_i,
	output logic done_o
);

	logic [10:0] count_ff;
	logic [10:0] nxt_count;
	wire logic saturated = (count_ff == 11'h7ff);

	// first tick may land at any phase, hence strictly greater than target
	assign nxt_count = !run_i ? 11'h000 :
		(tick_i && !saturated) ? count_ff + 11'h001 : count_ff;
	assign done_o = run_i && ((target_i == 11'h000) || (count_ff > target_i));

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			count_ff <= 11'h000;
		end else begin
			count_ff <= nxt_count;
		end
	end

endmodule

//--- src/ccr_charger_ctrl.sv
// Purpose: charger control register bank with the charge sequencing it steers
// Assumes: register port driven by the management-bus decoder on clock_i;
//   analog comparator flags arrive asynchronously and are synchronised here
// Notes: setpoint outputs are registered copies decoded from the fields
// Functional notes
// RQ1 - overvoltage in charge faults, optionally after 40 ms
// RQ2 - short threshold code selects crossover voltage
// RQ3 - below short threshold, charge at selected percent
// RQ4 - manual bit overrides automatic aux supply choice
// RQ5 - source bit: 0 input supply, 1 battery
// RQ6 - reduced limit gives 5.7A with range bit
// RQ7 - done current: stop converter or hold voltage
// RQ8 - compensation clamp off or 60-420 mV
// RQ9 - path compensation off or 20-140 mOhm
// RQ10 - in done state, restart below margin
// RQ11 - charger start delay none, 220ms, 500ms, 1.3s
// RQ12 - aux regulator fault stops charging unless ignored
// RQ13 - battery-good offset 0.4 to 1.0 V
// RQ14 - load from nonvolatile store; host reads, writes
`timescale 1ns/1ns
module ccr_charger_ctrl import ccr_pkg::*; #(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	// register port from the management bus
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// nonvolatile image delivered once after power-up
	input wire logic nvm_load_i,
	input wire ccr_image_t nvm_image_i,
	// switch range bit held in another register of the device
	input wire logic switch_limit_range_i,
	// asynchronous analog flags
	input wire logic charger_enable_i,
	input wire logic battery_overvoltage_i,
	input wire logic aux_supply_fault_i,
	input wire logic below_done_current_i,
	input wire logic below_restart_i,
	input wire logic below_short_i,
	input wire logic aux_auto_battery_i,
	// sequencing
	output ccr_state_t state_o,
	output logic converter_on_o,
	output logic hold_done_voltage_o,
	output logic fault_o,
	output logic short_charge_o,
	output ccr_setpoints_t setpoints_o
);

	localparam int NSYNC = 7;
	localparam int TW = $clog2(TICK_DIV + 1);
	// bit positions of the flags in the synchroniser bank
	localparam int S_EN = 6;
	localparam int S_OV = 5;
	localparam int S_AUX_FAULT = 4;
	localparam int S_DONE_CUR = 3;
	localparam int S_RESTART = 2;
	localparam int S_SHORT = 1;
	localparam int S_AUTO_BAT = 0;

	ccr_image_t image_ff;
	ccr_image_t nxt_image;
	ccr_setpoints_t setpoints_ff;
	ccr_setpoints_t nxt_setpoints;
	ccr_state_t state_ff;
	ccr_state_t nxt_state;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	logic [TW-1:0] div_ff;
	logic tick;
	logic ov_done;
	logic start_done;

	// two-stage synchronisers for every asynchronous flag
	wire logic [NSYNC-1:0] async_in = {
		charger_enable_i,
		battery_overvoltage_i,
		aux_supply_fault_i,
		below_done_current_i,
		below_restart_i,
		below_short_i,
		aux_auto_battery_i
	};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clock_i) begin
				if (!rst_n_i) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= async_in[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	wire logic en_s = sync2_ff[S_EN];
	wire logic ov_s = sync2_ff[S_OV];
	wire logic aux_fault_s = sync2_ff[S_AUX_FAULT];
	wire logic done_cur_s = sync2_ff[S_DONE_CUR];
	wire logic restart_s = sync2_ff[S_RESTART];
	wire logic short_s = sync2_ff[S_SHORT];
	wire logic auto_bat_s = sync2_ff[S_AUTO_BAT];

	// address decode, shared by the read mux and the write path
	function automatic logic [2:0] reg_hits(input logic [7:0] addr);
		if (addr == ADDR_CTRL_A) begin
			reg_hits = 3'b100;
		end else if (addr == ADDR_CTRL_B) begin
			reg_hits = 3'b010;
		end else if (addr == ADDR_CTRL_C) begin
			reg_hits = 3'b001;
		end else begin
			reg_hits = 3'b000;
		end
	endfunction

	// unmapped offsets read as zero so a probing host sees no stale byte
	function automatic logic [7:0] reg_word(input ccr_image_t img, input logic [7:0] addr);
		logic [2:0] h;
		h = reg_hits(addr);
		if (h[2]) begin
			reg_word = img.a;
		end else if (h[1]) begin
			reg_word = img.b;
		end else if (h[0]) begin
			reg_word = img.c;
		end else begin
			reg_word = 8'h00;
		end
	endfunction

	// register access decode
	wire logic [2:0] hits = reg_hits(reg_addr_i);
	wire logic hit_a = hits[2];
	wire logic hit_b = hits[1];
	wire logic hit_c = hits[0];
	wire logic [7:0] rd_mux = reg_word(image_ff, reg_addr_i);

	// host write wins over a coincident nonvolatile load on that register
	always_comb begin
		nxt_image = nvm_load_i ? nvm_image_i : image_ff; // RQ14
		if (reg_wr_i && hit_a) begin
			nxt_image.a = reg_wdata_i; // RQ14
		end else if (reg_wr_i && hit_b) begin
			nxt_image.b = reg_wdata_i;
		end else if (reg_wr_i && hit_c) begin
			nxt_image.c = reg_wdata_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			image_ff <= {RST_CTRL_A, RST_CTRL_B, RST_CTRL_C};
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			image_ff <= nxt_image;
			rdata_ff <= reg_rd_i ? rd_mux : rdata_ff; // RQ14
			rvalid_ff <= reg_rd_i;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign reg_rvalid_o = rvalid_ff;

	// setpoint decode
	wire ccr_ctrl_a_t fa = image_ff.a;
	wire ccr_ctrl_b_t fb = image_ff.b;
	wire ccr_ctrl_c_t fc = image_ff.c;
	wire logic [3:0] pct = 4'h1 << fa.short_current; // RQ3
	wire logic reduced = fb.reduced_switch_limit && switch_limit_range_i; // RQ6
	wire logic [6:0] lim = reduced ? LIMIT_REDUCED_DA :
		switch_limit_range_i ? LIMIT_HIGH_DA : LIMIT_LOW_DA; // RQ6
	wire logic [8:0] clamp = 9'(fb.path_comp_clamp * CLAMP_STEP_MV); // RQ8
	wire logic [7:0] comp = 8'(fb.path_resistance_comp * COMP_STEP_MOHM); // RQ9
	wire logic [9:0] bgood = 10'(BATGOOD_BASE_MV +
		fc.battery_ok_threshold * BATGOOD_STEP_MV); // RQ13
	// automatic choice comes from the analog supply monitor
	wire logic aux_bat = fa.aux_supply_manual ? fa.aux_supply_source : auto_bat_s; // RQ4 RQ5

	always_comb begin
		nxt_setpoints.short_threshold_mv = short_mv(fa.short_threshold); // RQ2
		nxt_setpoints.short_current_pct = pct;
		nxt_setpoints.aux_from_battery = aux_bat;
		nxt_setpoints.switch_limit_da = lim;
		nxt_setpoints.clamp_mv = clamp;
		nxt_setpoints.comp_mohm = comp;
		nxt_setpoints.restart_mv = restart_mv(fc.restart_margin); // RQ10
		nxt_setpoints.battery_ok_mv = bgood;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			setpoints_ff <= '0;
		end else begin
			setpoints_ff <= nxt_setpoints;
		end
	end

	assign setpoints_o = setpoints_ff;

	// millisecond enable
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			div_ff <= '0;
		end else begin
			div_ff <= tick ? '0 : div_ff + TW'(1);
		end
	end

	assign tick = (div_ff == TW'(TICK_DIV - 1));

	// charge sequencing
	wire logic regulating = (state_ff == CCR_CHARGE) ||
		((state_ff == CCR_DONE) && !fb.done_enable);
	wire logic ov_now = regulating && ov_s;

	ccr_ms_timer u_ov_filter (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.run_i(ov_now && fa.overvoltage_filter_enable),
		.target_i(OV_FILTER_MS),
		.done_o(ov_done)
	);

	ccr_ms_timer u_start_delay (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.run_i(state_ff == CCR_DELAY),
		.target_i(start_ms(fc.charger_start_delay)),
		.done_o(start_done)
	);

	wire logic ov_fault = fa.overvoltage_filter_enable ? ov_done : ov_now; // RQ1
	wire logic aux_fault = aux_fault_s && !fc.ignore_aux_supply_fault; // RQ12
	wire logic fault_event = ov_fault || aux_fault;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CCR_IDLE: begin
				if (en_s) begin
					nxt_state = CCR_DELAY;
				end
			end
			CCR_DELAY: begin
				if (!en_s) begin
					nxt_state = CCR_IDLE;
				end else if (aux_fault) begin
					nxt_state = CCR_FAULT; // RQ12
				end else if (start_done) begin
					nxt_state = CCR_CHARGE; // RQ11
				end
			end
			CCR_CHARGE: begin
				if (!en_s) begin
					nxt_state = CCR_IDLE;
				end else if (fault_event) begin
					nxt_state = CCR_FAULT; // RQ1 RQ12
				end else if (done_cur_s) begin
					nxt_state = CCR_DONE; // RQ7
				end
			end
			CCR_DONE: begin
				if (!en_s) begin
					nxt_state = CCR_IDLE;
				end else if (fault_event) begin
					nxt_state = CCR_FAULT; // RQ1 RQ12
				end else if (restart_s) begin
					nxt_state = CCR_CHARGE; // RQ10
				end
			end
			CCR_FAULT: begin
				// fault is left only by removing the enable
				if (!en_s) begin
					nxt_state = CCR_IDLE;
				end
			end
			default: nxt_state = CCR_IDLE;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_ff <= CCR_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign state_o = state_ff;
	assign converter_on_o = regulating; // RQ7
	assign hold_done_voltage_o = (state_ff == CCR_DONE) && !fb.done_enable; // RQ7
	assign fault_o = (state_ff == CCR_FAULT);
	assign short_charge_o = (state_ff == CCR_CHARGE) && short_s; // RQ3

endmodule

//--- tb/ccr_charger_ctrl_props.sv
// Purpose: port-level checks of the charger control registers
// Assumes: one clock, synchronous active-low reset
// Notes: long delays are timed by the bench, not here
`timescale 1ns/1ns
module ccr_charger_ctrl_props import ccr_pkg::*; #(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire ccr_state_t state_o,
	input wire logic converter_on_o,
	input wire logic hold_done_voltage_o,
	input wire logic fault_o,
	input wire logic short_charge_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire logic unmapped = reg_addr_i < ADDR_CTRL_A || reg_addr_i > ADDR_CTRL_C;
	read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	answer_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
		else $error("answer without read");
	unmapped_zero_a: assert property (reg_rd_i && unmapped |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	start_via_delay_a: assert property (state_o == CCR_IDLE |=> state_o inside {CCR_IDLE, CCR_DELAY})
		else $error("start skipped delay");
	fault_stands_a: assert property (state_o == CCR_FAULT |=> state_o inside {CCR_FAULT, CCR_IDLE})
		else $error("fault left early");
	fault_flag_a: assert property (fault_o == (state_o == CCR_FAULT))
		else $error("fault flag wrong");
	hold_on_a: assert property (hold_done_voltage_o |-> converter_on_o && state_o == CCR_DONE)
		else $error("hold outside done");
	converter_states_a: assert property (converter_on_o |-> state_o inside {CCR_CHARGE, CCR_DONE})
		else $error("converter on when idle");
	short_in_charge_a: assert property (short_charge_o |-> state_o == CCR_CHARGE)
		else $error("short charge outside charge");
endmodule
bind ccr_charger_ctrl ccr_charger_ctrl_props #(.TICK_DIV(TICK_DIV)) i_props(.clock_i, .rst_n_i,
	.reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .state_o, .converter_on_o,
	.hold_done_voltage_o, .fault_o, .short_charge_o);

//--- tb/ccr_host_model.sv
// Purpose: host side of the register port, single reads and writes
// Assumes: strobes are sampled on the rising clock edge
// Notes: released address and data are inverted so stale values never pass
`timescale 1ns/1ns
module ccr_host_model (
	input wire logic clock_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_rvalid_i
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#10;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge clock_i);
		#10;
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		#10;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge clock_i);
		#10;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
	endtask
endmodule

//--- tb/ccr_charger_ctrl_tb.sv
// Purpose: self-checking bench of the charger control registers
// Assumes: TICK_DIV of 10, so one millisecond is ten cycles
// Notes: setpoints are predicted from integer tables kept here
`timescale 1ns/1ns
module ccr_charger_ctrl_tb import ccr_pkg::*;;
	logic clock_i = 0, rst_n_i = 0, nvm_load_i = 0, rng = 0, en = 0, ov = 0, af = 0;
	logic bdc = 0, brs = 0, bsh = 0, aab = 0, wr, rd, rvalid, conv, hold, flt, shc;
	logic [7:0] addr, wdata, rdata, d;
	ccr_image_t img = '0;
	ccr_state_t st;
	ccr_setpoints_t sp, e;
	int num_errors = 0, num_checks = 0, seed = 61899, mdl[3], k;
	int sh[8] = '{4000, 5000, 6000, 7500, 8000, 10000, 10000, 12500};
	int rs[8] = '{200, 300, 400, 450, 500, 600, 750, 800};
	always #50 clock_i = ~clock_i;
	ccr_host_model i_host(.clock_i, .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
	ccr_charger_ctrl #(.TICK_DIV(10)) i_dut(.clock_i, .rst_n_i, .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .nvm_load_i, .nvm_image_i(img), .switch_limit_range_i(rng),
		.charger_enable_i(en), .battery_overvoltage_i(ov), .aux_supply_fault_i(af),
		.below_done_current_i(bdc), .below_restart_i(brs), .below_short_i(bsh),
		.aux_auto_battery_i(aab), .state_o(st), .converter_on_o(conv),
		.hold_done_voltage_o(hold), .fault_o(flt), .short_charge_o(shc), .setpoints_o(sp));
	task automatic chk(input string n, input logic [63:0] x, input logic [63:0] y);
		num_checks++;
		if (x !== y) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, x, y);
		end
	endtask
	task automatic finish_test;
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#10;
	endtask
	task automatic wait_st(input ccr_state_t s, input int n);
		int i;
		i = 0;
		while (st !== s && i < n) begin
			cyc(1);
			i++;
		end
		chk("state", s, st);
	endtask
	task automatic rd_chk(input int i);
		i_host.rd(ADDR_CTRL_A + 8'(i), d);
		chk("reg", mdl[i], d);
	endtask
	task automatic sp_chk;
		logic [7:0] a, b, c;
		a = 8'(mdl[0]);
		b = 8'(mdl[1]);
		c = 8'(mdl[2]);
		e.short_threshold_mv = 14'(sh[a[6:4]]);
		e.short_current_pct = 4'(1 << a[3:2]);
		e.aux_from_battery = a[1] ? a[0] : aab;
		e.switch_limit_da = (b[7] && rng) ? 7'h39 : (rng ? 7'h64 : 7'h55);
		e.clamp_mv = 9'(60 * b[5:3]);
		e.comp_mohm = 8'(20 * b[2:0]);
		e.restart_mv = 10'(rs[c[7:5]]);
		e.battery_ok_mv = 10'(400 + 200 * c[1:0]);
		chk("setpoints", e, sp);
	endtask
	initial begin
		cyc(30000);
		num_errors++;
		finish_test();
	end
	initial begin
		cyc(6);
		rst_n_i = 1;
		mdl = '{8'h98, 8'h40, 8'h49};
		cyc(2);
		for (k = 0; k < 3; k++) rd_chk(k);
		sp_chk();
		i_host.rd(8'h0e, d);
		chk("unmapped", 8'h00, d);
		for (k = 0; k < 24; k++) begin
			rng = 1'($random(seed));
			aab = 1'($random(seed));
			mdl[k % 3] = $random(seed) & 255;
			i_host.wr(ADDR_CTRL_A + 8'(k % 3), 8'(mdl[k % 3]));
			rd_chk(k % 3);
			sp_chk();
		end
		img = 24'($random(seed));
		nvm_load_i = 1;
		cyc(1);
		nvm_load_i = 0;
		mdl = '{img.a, img.b, img.c};
		for (k = 0; k < 3; k++) rd_chk(k);
		// filter off and no start delay, so transitions are quick
		i_host.wr(ADDR_CTRL_A, 8'h18);
		i_host.wr(ADDR_CTRL_B, 8'h40);
		i_host.wr(ADDR_CTRL_C, 8'h00);
		en = 1;
		wait_st(CCR_CHARGE, 8);
		bsh = 1;
		cyc(4);
		chk("short", 1, shc);
		bsh = 0;
		bdc = 1;
		wait_st(CCR_DONE, 8);
		chk("conv", 0, conv);
		bdc = 0;
		brs = 1;
		wait_st(CCR_CHARGE, 8);
		brs = 0;
		ov = 1;
		wait_st(CCR_FAULT, 5);
		chk("fault", 1, flt);
		ov = 0;
		en = 0;
		wait_st(CCR_IDLE, 5);
		i_host.wr(ADDR_CTRL_B, 8'h00);
		i_host.wr(ADDR_CTRL_C, 8'h04);
		en = 1;
		bdc = 1;
		wait_st(CCR_DONE, 12);
		chk("hold", 2'h3, {hold, conv});
		af = 1;
		cyc(10);
		chk("state", CCR_DONE, st);
		chk("fault", 0, flt);
		i_host.wr(ADDR_CTRL_C, 8'h00);
		wait_st(CCR_FAULT, 5);
		chk("fault", 1, flt);
		af = 0;
		bdc = 0;
		en = 0;
		wait_st(CCR_IDLE, 5);
		i_host.wr(ADDR_CTRL_A, 8'h98);
		i_host.wr(ADDR_CTRL_C, 8'h08);
		en = 1;
		wait_st(CCR_DELAY, 5);
		cyc(2150);
		chk("state", CCR_DELAY, st);
		wait_st(CCR_CHARGE, 100);
		ov = 1;
		cyc(390);
		chk("state", CCR_CHARGE, st);
		wait_st(CCR_FAULT, 60);
		chk("fault", 1, flt);
		// longer start delays: 500 ms and 1.3 s at ten cycles a tick
		for (k = 2; k < 4; k++) begin
			ov = 0;
			en = 0;
			wait_st(CCR_IDLE, 5);
			i_host.wr(ADDR_CTRL_C, 8'(k << 3));
			en = 1;
			wait_st(CCR_DELAY, 5);
			// stop 50 cycles short of the delay
			cyc(k == 2 ? 4950 : 12950);
			chk("state", CCR_DELAY, st);
			wait_st(CCR_CHARGE, 100);
		end
		finish_test();
	end
endmodule
